// ---- rtl/fcs_top.sv ----
// fcs_top: flash command sequencer with avalon-mm register slave
// assumes: single 20 MHz clock, synchronous active-high reset, array macro
// outside takes fcs_arr_t and reports blank result; stop request is a pin
`timescale 1ns/1ps
`include "fcs_params.svh"

module fcs_top #(
  parameter int PAGE_INTERNAL_FLASH_CLOCK = `FCS_T_PAGE,  // page erase flash clocks
  parameter int MASS_INTERNAL_FLASH_CLOCK = `FCS_T_MASS   // mass erase flash clocks
) (
  input  wire logic           clock,             // bus clock, 20 MHz
  input  wire logic           rst,               // sync reset, high
  input  wire logic [18:0]    avs_address,       // byte address
  input  wire logic           avs_read,          // read request
  input  wire logic           avs_write,         // write request
  input  wire logic [31:0]    avs_writedata,     // write data
  input  wire logic [3:0]     avs_byteenable,    // byte lanes
  output logic [31:0]         avs_readdata,      // read data
  output logic                avs_waitrequest,   // stall
  input  wire logic           bdm_access,        // access from debug port
  input  wire logic           stop_req,          // stop mode pin, async
  input  wire logic [7:0]     nv_prot_byte,      // protection byte
  input  wire logic [7:0]     nv_opt_byte,       // option byte
  input  wire logic           arr_blank_ok,      // array reads erased
  input  wire logic [15:0]    vec_addr_in,       // vector fetch address
  output logic [15:0]         vec_addr_out,      // redirected address
  output fcs_pkg::fcs_arr_t   arr_ctl            // array control
);
  import fcs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // declarations
  logic            wait_q;        // waitrequest flop
  logic [31:0]     rdata_q;       // read data flop
  logic            divisor_loaded_flag_q;       // divisor loaded
  logic [6:0]      div_q;         // prescale bit and divider
  logic [2:0]      pre_cnt_q;     // divide-by-eight count
  logic [5:0]      div_cnt_q;     // divider count
  logic            tick_q;        // one-cycle flash clock enable
  logic            stop_s1_q;     // stop sync first stage
  logic            stop_s2_q;     // stop sync second stage
  logic            stop_s3_q;     // stop sync third stage
  logic            stop_q;        // debounced stop level
  logic            load_q;        // nonvolatile load pending
  logic [7:0]      prot_q;        // working protection
  logic [7:0]      opt_q;         // working options
  fcs_buf_t        stage_q;       // buffer stage
  fcs_req_t        buf_q;         // buffered command
  logic            pend_q;        // launched, not yet taken
  logic            acc_q;         // access error flag
  logic            pviol_q;       // protection violation flag
  fcs_seq_t        seq_q;         // sequencer state
  logic [14:0]     cnt_q;         // flash clocks remaining
  fcs_req_t        cur_q;         // command being run
  logic            pump_q;        // charge pump on
  fcs_arr_t        arr_q;         // array control flop
  logic [15:0]     vec_q;         // redirected vector flop

  //////////////////////////////////////////////////////////////////////////
  // functions
  // last unprotected address: select bits then ones
  function automatic logic is_prot(input logic [7:0]  p,
                                   input logic [15:0] a);
    is_prot = ~p[`FCS_PROT_PDIS] & (a > {p[7:1], 9'h1FF});
  endfunction
  // same 64-byte row and not its first byte
  function automatic logic same_row(input logic [15:0] a,
                                    input logic [15:0] b);
    same_row = (a[15:6] == b[15:6]) & (a[5:0] != 6'h00);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  wire         wr_take  = avs_write & ~wait_q;   // write takes effect
  wire         hit_arr  = avs_address[`FCS_ARR_BIT];
  wire         hit_div  = avs_address == `FCS_OFS_DIV;
  wire         hit_prot = avs_address == `FCS_OFS_PROT;
  wire         hit_cmd  = avs_address == `FCS_OFS_CMD;
  wire         hit_stat = avs_address == `FCS_OFS_STAT;
  wire         hit_opt  = avs_address == `FCS_OFS_OPT;
  wire         lane0    = avs_byteenable[0];
  wire         w_arr    = wr_take & hit_arr & lane0;
  wire         w_div    = wr_take & hit_div & lane0;
  wire         w_prot   = wr_take & hit_prot & lane0;
  wire         w_cmd    = wr_take & hit_cmd & lane0;
  wire         w_stat   = wr_take & hit_stat & lane0;
  wire         w_opt    = wr_take & hit_opt & lane0;
  wire [7:0]   wd       = avs_writedata[7:0];

  //////////////////////////////////////////////////////////////////////////
  // command and status decode
  wire         busy      = seq_q == FCS_SEQ_RUN;
  wire         st_empty  = stage_q == FCS_BUF_EMPTY;
  wire         cbef      = st_empty & ~pend_q;
  wire         ccf       = ~busy & ~pend_q;
  wire         secure    = opt_q[1:0] != `FCS_OPT_UNSEC;
  wire         code_ok   = (wd == `FCS_CMD_BLANK) |
                           (wd == `FCS_CMD_PAGE) |
                           (wd == `FCS_CMD_MASS) |
                           (wd == `FCS_CMD_BYTE) |
                           (wd == `FCS_CMD_BURST);
  wire         code_lock = (wd == `FCS_CMD_BYTE) |
                           (wd == `FCS_CMD_BURST) |
                           (wd == `FCS_CMD_PAGE);
  wire         err_arr   = w_arr & (~divisor_loaded_flag_q | ~cbef);
  wire         err_cmd   = w_cmd & ~st_empty &
                           ((stage_q == FCS_BUF_CMD) | ~code_ok |
                            (secure & bdm_access & code_lock));
  wire         err_ctl   = (w_div | w_prot | w_opt) & ~st_empty;
  wire         err_abort = w_stat & ~wd[`FCS_ST_CBEF] & ~st_empty;
  wire         err_stop  = stop_q & busy;
  wire         done      = busy & tick_q & (cnt_q == 15'd1);
  wire         err_blank = done & (cur_q.cmd == `FCS_CMD_BLANK) &
                           ~arr_blank_ok;
  wire         any_err   = err_arr | err_cmd | err_ctl | err_abort |
                           err_stop | err_blank;
  wire         launch    = w_stat & wd[`FCS_ST_CBEF] & ~acc_q &
                           (stage_q == FCS_BUF_CMD);
  wire         viol      = ((buf_q.cmd == `FCS_CMD_MASS) &
                            ~prot_q[`FCS_PROT_PDIS]) |
                           ((buf_q.cmd != `FCS_CMD_MASS) &
                            (buf_q.cmd != `FCS_CMD_BLANK) &
                            is_prot(prot_q, buf_q.addr));
  wire         is_burst  = cur_q.cmd == `FCS_CMD_BURST;
  wire         keep_pump = is_burst & pend_q &
                           (buf_q.cmd == `FCS_CMD_BURST) &
                           same_row(buf_q.addr, cur_q.addr);
  wire         fast      = pump_q & (buf_q.cmd == `FCS_CMD_BURST);
  wire         take      = pend_q & ~busy & ~stop_q;
  wire         prot_grow = wd[7:1] < prot_q[7:1];

  // flash clock count for the command about to run
  logic [14:0] t_run;
  always_comb begin
    t_run = `FCS_T_BYTE;
    if (buf_q.cmd == `FCS_CMD_PAGE) begin
      t_run = PAGE_INTERNAL_FLASH_CLOCK[14:0];
    end else if (buf_q.cmd == `FCS_CMD_MASS) begin
      t_run = MASS_INTERNAL_FLASH_CLOCK[14:0];
    end else if (buf_q.cmd == `FCS_CMD_BLANK) begin
      t_run = `FCS_T_BLANK;
    end else if (fast) begin
      t_run = `FCS_T_BURST;
    end
  end

  // register read mux
  wire [7:0]   st_byte  = {cbef, ccf, pviol_q, acc_q, 4'h0};
  wire [7:0]   rd_byte  = hit_div  ? {divisor_loaded_flag_q, div_q} :
                          hit_prot ? prot_q :
                          hit_stat ? st_byte :
                          hit_opt  ? opt_q : 8'h00;

  // vector redirection below the protected boundary
  wire         vec_in_win = (vec_addr_in >= `FCS_VEC_LO) &
                            (vec_addr_in <= `FCS_VEC_HI);
  wire         redirect   = ~opt_q[`FCS_OPT_NORED] & vec_in_win &
                            ~prot_q[`FCS_PROT_PDIS] & ~&prot_q[7:1];

  //////////////////////////////////////////////////////////////////////////
  // avalon handshake: one wait cycle, then answer
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
    end
  end

  // read data captured in the wait cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read & wait_q) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // divider register, write once
  always_ff @(posedge clock) begin
    if (rst) begin
      divisor_loaded_flag_q <= 1'b0;
      div_q   <= `FCS_RST_DIV;
    end else if (w_div & ~divisor_loaded_flag_q & st_empty) begin
      divisor_loaded_flag_q <= 1'b1;
      div_q   <= wd[6:0];
    end
  end

  // flash clock enable: optional divide by eight, then div+1
  always_ff @(posedge clock) begin
    if (rst | ~divisor_loaded_flag_q) begin
      pre_cnt_q <= 3'h0;
      div_cnt_q <= 6'h00;
      tick_q    <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 3'h1;
      tick_q    <= 1'b0;
      if (~div_q[`FCS_DIV_PRE] | (pre_cnt_q == `FCS_PRE_LAST)) begin
        if (div_cnt_q == div_q[5:0]) begin
          div_cnt_q <= 6'h00;
          tick_q    <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 6'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // stop pin synchroniser, change counts when stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
      stop_s3_q <= 1'b0;
      stop_q    <= 1'b0;
    end else begin
      stop_s1_q <= stop_req;
      stop_s2_q <= stop_s1_q;
      stop_s3_q <= stop_s2_q;
      if (stop_s2_q == stop_s3_q) begin
        stop_q <= stop_s3_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // protection and option registers, loaded after reset release
  always_ff @(posedge clock) begin
    if (rst) begin
      load_q <= 1'b1;
      prot_q <= `FCS_RST_BYTE;
      opt_q  <= `FCS_RST_BYTE;
    end else if (load_q) begin
      load_q <= 1'b0;
      prot_q <= nv_prot_byte;
      opt_q  <= nv_opt_byte;
    end else if (w_prot & st_empty) begin
      if (prot_q[`FCS_PROT_PDIS]) begin
        prot_q <= wd;
      end else if (prot_grow) begin
        prot_q <= {wd[7:1], 1'b0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command buffer: array write, command write, launch
  always_ff @(posedge clock) begin
    if (rst) begin
      stage_q <= FCS_BUF_EMPTY;
      buf_q   <= '0;
      pend_q  <= 1'b0;
    end else begin
      if (take) begin
        pend_q <= 1'b0;
      end
      if (any_err & ~err_stop & ~err_blank) begin
        stage_q <= FCS_BUF_EMPTY;
      end else if (w_arr & ~acc_q & (stage_q == FCS_BUF_EMPTY)) begin
        stage_q    <= FCS_BUF_ADDR;
        buf_q.addr <= avs_address[17:2];
        buf_q.data <= wd;
      end else if (w_cmd & ~acc_q & (stage_q == FCS_BUF_ADDR)) begin
        stage_q   <= FCS_BUF_CMD;
        buf_q.cmd <= wd;
      end else if (launch) begin
        stage_q <= FCS_BUF_EMPTY;
        pend_q  <= ~viol;
      end
    end
  end

  // error flags: a set in the same cycle beats the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q   <= 1'b0;
      pviol_q <= 1'b0;
    end else begin
      acc_q   <= any_err |
                 (acc_q & ~(w_stat & wd[`FCS_ST_ACCERR]));
      pviol_q <= (launch & viol) |
                 (pviol_q & ~(w_stat & wd[`FCS_ST_PVIOL]));
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer: times pulses in flash clock cycles
  always_ff @(posedge clock) begin
    if (rst) begin
      seq_q  <= FCS_SEQ_IDLE;
      cnt_q  <= 15'd0;
      cur_q  <= '0;
      pump_q <= 1'b0;
    end else begin
      case (seq_q)
        FCS_SEQ_IDLE: begin
          if (take) begin
            seq_q  <= FCS_SEQ_RUN;
            cur_q  <= buf_q;
            cnt_q  <= t_run;
            pump_q <= buf_q.cmd != `FCS_CMD_BLANK;
          end else if (~pend_q) begin
            pump_q <= 1'b0;
          end
        end
        FCS_SEQ_RUN: begin
          if (stop_q) begin
            seq_q  <= FCS_SEQ_IDLE;
            pump_q <= 1'b0;
          end else if (done) begin
            seq_q  <= FCS_SEQ_IDLE;
            pump_q <= keep_pump;
          end else if (tick_q) begin
            cnt_q <= cnt_q - 15'd1;
          end
        end
        default: begin
          seq_q <= FCS_SEQ_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // array control and vector outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      arr_q <= '0;
      vec_q <= 16'h0000;
    end else begin
      arr_q.addr       <= cur_q.addr;
      arr_q.data       <= cur_q.data;
      arr_q.prog       <= busy & ((cur_q.cmd == `FCS_CMD_BYTE) | is_burst);
      arr_q.erase_page <= busy & (cur_q.cmd == `FCS_CMD_PAGE);
      arr_q.erase_mass <= busy & (cur_q.cmd == `FCS_CMD_MASS);
      arr_q.blank      <= busy & (cur_q.cmd == `FCS_CMD_BLANK);
      arr_q.hv_pump    <= pump_q;
      vec_q            <= redirect ? {prot_q[7:1], vec_addr_in[8:0]}
                                   : vec_addr_in;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign arr_ctl         = arr_q;
  assign vec_addr_out    = vec_q;

endmodule // fcs_top

// ---- rtl/fcs_params.svh ----
// fcs_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from fcs_top, fcs_asserts and testbench
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
// register byte addresses on the avalon slave (array window at bit 18)
`define FCS_OFS_DIV     19'h00000
`define FCS_OFS_PROT    19'h00004
`define FCS_OFS_CMD     19'h00008
`define FCS_OFS_STAT    19'h0000C
`define FCS_OFS_OPT     19'h00010
`define FCS_ARR_BIT     18
// nonvolatile byte locations at the top of the array
`define FCS_NONVOLATILE_PROTECTION_BYTE_ADDR 16'hFFBD
`define FCS_NONVOLATILE_OPTION_BYTE_ADDR  16'hFFBF
// field positions
`define FCS_DIV_LD      7
`define FCS_DIV_PRE     6
`define FCS_ST_CBEF     7
`define FCS_ST_CCF      6
`define FCS_ST_PVIOL    5
`define FCS_ST_ACCERR   4
`define FCS_PROT_PDIS   0
`define FCS_OPT_NORED   6
`define FCS_OPT_UNSEC   2'h2
// command codes
`define FCS_CMD_BLANK   8'h05
`define FCS_CMD_BYTE    8'h20
`define FCS_CMD_BURST   8'h25
`define FCS_CMD_PAGE    8'h40
`define FCS_CMD_MASS    8'h41
// vector window
`define FCS_VEC_LO      16'hFFC0
`define FCS_VEC_HI      16'hFFFD
// timing counts in flash clock cycles, prescaler last count in bus cycles
`define FCS_T_BYTE      15'd9
`define FCS_T_BURST     15'd4
`define FCS_T_PAGE      4000
`define FCS_T_MASS      20000
`define FCS_T_BLANK     15'd9
`define FCS_PRE_LAST    3'h7
// reset values
`define FCS_RST_DIV     7'h00
`define FCS_RST_BYTE    8'h00
`endif

// ---- rtl/fcs_pkg.sv ----
// fcs_pkg: types shared by the flash command sequencer
// assumes: fcs_params.svh sits beside it
package fcs_pkg;
  // command buffer stage, one-hot
  typedef enum logic [2:0] {
    FCS_BUF_EMPTY = 3'b001,   // waiting for array write
    FCS_BUF_ADDR  = 3'b010,   // address and data latched
    FCS_BUF_CMD   = 3'b100    // command code latched
  } fcs_buf_t;
  // sequencer state, one-hot
  typedef enum logic [1:0] {
    FCS_SEQ_IDLE = 2'b01,     // nothing running
    FCS_SEQ_RUN  = 2'b10      // timing a pulse
  } fcs_seq_t;
  // one buffered command
  typedef struct packed {
    logic [15:0] addr;        // array byte address
    logic [7:0]  data;        // program data
    logic [7:0]  cmd;         // command code
  } fcs_req_t;
  // drive towards the array macro
  typedef struct packed {
    logic [15:0] addr;        // latched address
    logic [7:0]  data;        // latched data
    logic        prog;        // program pulse active
    logic        erase_page;  // page erase active
    logic        erase_mass;  // mass erase active
    logic        blank;       // blank check active
    logic        hv_pump;     // charge pump on
  } fcs_arr_t;
endpackage

// ---- verif/fcs_asserts.sv ----
// fcs_asserts: port-level checker for fcs_top, bound below
// assumes: one clock domain, sync active-high reset on rst
`timescale 1ns/1ps
`include "fcs_params.svh"
module fcs_asserts #(
  parameter int PAGE_INTERNAL_FLASH_CLOCK = 20,  // page erase flash clocks
  parameter int MASS_INTERNAL_FLASH_CLOCK = 40   // mass erase flash clocks
) (
  input wire logic              clock,            // bus clock
  input wire logic              rst,              // sync reset
  input wire logic [18:0]       avs_address,      // byte address
  input wire logic              avs_read,         // read request
  input wire logic              avs_write,        // write request
  input wire logic              avs_waitrequest,  // stall
  input wire logic              stop_req,         // stop mode
  input wire logic [15:0]       vec_addr_in,      // vector fetch
  input wire logic [15:0]       vec_addr_out,     // vector out
  input wire fcs_pkg::fcs_arr_t arr_ctl           // array control
);
  import fcs_pkg::*;
  ////////////////////////////////////////////////////////////////////
  logic div_seen_q;  // divider written since reset
  wire  op_on = arr_ctl.prog | arr_ctl.erase_page | arr_ctl.erase_mass
              | arr_ctl.blank;  // any array operation
  // remember the first accepted divider write
  always_ff @(posedge clock) begin
    if (rst) div_seen_q <= 1'b0;
    else if (avs_write && !avs_waitrequest
             && avs_address == `FCS_OFS_DIV) div_seen_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
  property p_ack; s_req |=> s_ans; endproperty
  property p_div; $rose(op_on) |-> div_seen_q; endproperty
  property p_prog; $rose(arr_ctl.prog) |-> arr_ctl.prog [*7]; endproperty
  property p_page; $rose(arr_ctl.erase_page) |-> arr_ctl.erase_page [*8];
  endproperty
  property p_one; $onehot0({arr_ctl.prog, arr_ctl.erase_page,
    arr_ctl.erase_mass, arr_ctl.blank}); endproperty
  property p_pump; arr_ctl.prog |-> arr_ctl.hv_pump; endproperty
  property p_stop; stop_req && op_on |-> ##[1:8] !op_on; endproperty
  property p_vec; vec_addr_in[15:1] == 15'h7FFF |=>
    vec_addr_out == $past(vec_addr_in); endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  a_div: assert property (p_div) else $error("op before divider");
  a_prog: assert property (p_prog) else $error("program short");
  a_page: assert property (p_page) else $error("page erase short");
  a_one: assert property (p_one) else $error("two ops at once");
  a_pump: assert property (p_pump) else $error("pump off in prog");
  a_stop: assert property (p_stop) else $error("stop not abort");
  a_vec: assert property (p_vec) else $error("reset vector moved");
endmodule // fcs_asserts
bind fcs_top fcs_asserts #(.PAGE_INTERNAL_FLASH_CLOCK(PAGE_INTERNAL_FLASH_CLOCK), .MASS_INTERNAL_FLASH_CLOCK(MASS_INTERNAL_FLASH_CLOCK))
  fcs_asserts_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .stop_req(stop_req),
  .vec_addr_in(vec_addr_in), .vec_addr_out(vec_addr_out),
  .arr_ctl(arr_ctl));

// ---- verif/fcs_arr_model.sv ----
// fcs_arr_model: flash array stand-in that reports blank state
// assumes: driven by fcs_top arr_ctl on the same clock
`timescale 1ns/1ps
module fcs_arr_model (
  input wire logic              clock,        // bus clock
  input wire logic              rst,          // sync reset
  input wire fcs_pkg::fcs_arr_t arr_ctl,      // array control
  output logic                  arr_blank_ok  // array reads erased
);
  import fcs_pkg::*;
  logic erased_q;  // whole array erased
  // mass erase blanks the array, any program dirties it
  always_ff @(posedge clock) begin
    if (rst) erased_q <= 1'b0;
    else if (arr_ctl.erase_mass) erased_q <= 1'b1;
    else if (arr_ctl.prog) erased_q <= 1'b0;
  end
  assign arr_blank_ok = erased_q;  // level to the sequencer
endmodule // fcs_arr_model

// ---- verif/testbench.sv ----
// testbench: directed scenarios for fcs_top over avalon-mm
// assumes: divider 0x01 gives a two bus cycle flash tick
`timescale 1ns/1ps
`include "fcs_params.svh"
module testbench;
  import fcs_pkg::*;
  logic        clock, rst, avs_read, avs_write, stop_req, bdm_access;
  logic [18:0] avs_address;                    // byte address
  logic [31:0] avs_writedata, avs_readdata;    // data buses
  logic        avs_waitrequest, arr_blank_ok;  // answers
  logic [15:0] vec_addr_in, vec_addr_out;      // vector fetch
  logic [7:0]  q;                              // last read byte
  fcs_arr_t    arr_ctl, cap;                   // array control
  int          miscompares, tests_run, len;    // counters
  fcs_top #(.PAGE_INTERNAL_FLASH_CLOCK(20), .MASS_INTERNAL_FLASH_CLOCK(40)) fcs_top_inst (
    .clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bdm_access(bdm_access), .stop_req(stop_req), .nv_prot_byte(8'hFF),
    .nv_opt_byte(8'hBE), .arr_blank_ok(arr_blank_ok),
    .vec_addr_in(vec_addr_in), .vec_addr_out(vec_addr_out),
    .arr_ctl(arr_ctl));
  fcs_arr_model fcs_arr_model_inst (.clock(clock), .rst(rst),
    .arr_ctl(arr_ctl), .arr_blank_ok(arr_blank_ok));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic conclude;
    $display("mismatches %0d of %0d compares", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  // one avalon transfer, held until waitrequest low
  task automatic bus(input logic w, input logic [18:0] a,
                     input logic [7:0] d);
    int n;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      conclude();
    end
    @(posedge clock);
  endtask
  function automatic logic [18:0] arr(input logic [15:0] i);
    return {1'b1, i, 2'b00};  // array window byte address
  endfunction
  function automatic logic busy(input bit pump);
    return pump ? arr_ctl.hv_pump : (arr_ctl.prog | arr_ctl.erase_page
      | arr_ctl.erase_mass | arr_ctl.blank);
  endfunction
  task automatic stat(input logic [7:0] e);
    bus(1'b0, `FCS_OFS_STAT, 8'h00);
    chk(q, e);
  endtask
  task automatic cmd(input logic [15:0] a, input logic [7:0] d, c);
    bus(1'b1, arr(a), d);
    bus(1'b1, `FCS_OFS_CMD, c);
    bus(1'b1, `FCS_OFS_STAT, 8'h80);
  endtask
  // length of the next busy stretch, first cycle captured
  task automatic meas(input bit pump);
    int n;
    n = 0;
    len = 0;
    while (busy(pump) !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    cap = arr_ctl;
    while (busy(pump) === 1'b1 && len < 400) begin
      @(posedge clock);
      len++;
    end
    if (len >= 400 || n >= 20) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic near(input int e);
    chk(len >= e - 2 && len <= e + 2, 1);
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_nodiv;
    bus(1'b1, arr(16'h0100), 8'h11);
    stat(8'hD0);
    bus(1'b1, `FCS_OFS_STAT, 8'h10);
    stat(8'hC0);
  endtask
  task automatic t_div;
    bus(1'b1, `FCS_OFS_DIV, 8'h01);
    bus(1'b1, `FCS_OFS_DIV, 8'h3F);
    bus(1'b0, `FCS_OFS_DIV, 8'h00);
    chk(q, 8'h81);
  endtask
  task automatic t_byte;
    bdm_access <= 1'b1;
    cmd(16'h1000, 8'h5A, `FCS_CMD_BYTE);
    bdm_access <= 1'b0;
    meas(0);
    near(18);
    chk(cap.addr, 16'h1000);
    chk(cap.data, 8'h5A);
    chk(cap.prog, 1'b1);
    stat(8'hC0);
  endtask
  task automatic t_erase;
    cmd(16'h1234, 8'h00, `FCS_CMD_PAGE);
    meas(0);
    near(40);
    chk(cap.erase_page, 1'b1);
    cmd(16'h0000, 8'h00, `FCS_CMD_MASS);
    meas(0);
    near(80);
    chk(cap.erase_mass, 1'b1);
    cmd(16'h0003, 8'h00, `FCS_CMD_BLANK);
    meas(0);
    chk(cap.blank, 1'b1);
    stat(8'hC0);
  endtask
  task automatic t_err(input logic [18:0] a, input logic [7:0] d);
    bus(1'b1, arr(16'h0005), 8'h01);
    bus(1'b1, a, d);
    stat(8'hD0);
    bus(1'b1, `FCS_OFS_STAT, 8'h10);
    stat(8'hC0);
  endtask
  task automatic t_burst;
    cmd(16'h2000, 8'h01, `FCS_CMD_BURST);
    fork
      meas(1);
      cmd(16'h2001, 8'h02, `FCS_CMD_BURST);
    join
    near(26);
    stat(8'hC0);
  endtask
  task automatic t_stop;
    cmd(16'h1400, 8'h00, `FCS_CMD_PAGE);
    repeat (6) @(posedge clock);
    stop_req <= 1'b1;
    repeat (12) @(posedge clock);
    chk(busy(0), 1'b0);
    stat(8'hD0);
    stop_req <= 1'b0;
    bus(1'b1, `FCS_OFS_STAT, 8'h10);
  endtask
  // protect top 512 bytes, redirect vectors, refuse protected erase
  task automatic t_prot;
    bus(1'b1, `FCS_OFS_PROT, 8'hFC);
    vec_addr_in <= 16'hFFE0;
    repeat (2) @(posedge clock);
    chk(vec_addr_out, 16'hFDE0);
    bus(1'b1, `FCS_OFS_PROT, 8'hFE);
    bus(1'b0, `FCS_OFS_PROT, 8'h00);
    chk(q, 8'hFC);
    cmd(16'hFF00, 8'h00, `FCS_CMD_PAGE);
    stat(8'hE0);
    bus(1'b1, `FCS_OFS_STAT, 8'h20);
    stat(8'hC0);
    vec_addr_in <= 16'hFFFE;
    repeat (2) @(posedge clock);
    chk(vec_addr_out, 16'hFFFE);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    {avs_read, avs_write, stop_req, avs_address, avs_writedata} = '0;
    bdm_access = 1'b0;
    vec_addr_in = 16'hFFFE;
    miscompares = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    stat(8'hC0);
    bus(1'b0, `FCS_OFS_DIV, 8'h00);
    chk(q, 8'h00);
    t_nodiv();
    t_div();
    t_byte();
    t_erase();
    t_err(`FCS_OFS_STAT, 8'h00);
    t_err(`FCS_OFS_CMD, 8'h33);
    t_err(arr(16'h0006), 8'h02);
    t_err(`FCS_OFS_PROT, 8'hFF);
    t_burst();
    t_stop();
    t_prot();
    conclude();
  end
endmodule // testbench
